//--- hw/tio_pkg.sv
// timed i/o port block: shared constants, register map and state types.
// assumes a single 40 MHz bus clock; pin-side levels are synchronised in the block.
package tio_pkg;
	localparam int NPORT = 6;
	localparam int NCB = 6;
	localparam int NPIN = 32;
	localparam int CNT_W = 16;
	// port widths, ascending so that a lower index is never wider
	localparam int PORT_W [NPORT] = '{1, 1, 4, 8, 16, 32};
	localparam int PORT_BASE [NPORT] = '{0, 1, 0, 0, 0, 0};
	// tile reference clock and bus clock rates
	localparam longint CLK_HZ = 40_000_000;
	localparam longint REF_HZ = 100_000_000;
	localparam int REF_DIV = (CLK_HZ / REF_HZ) < 1 ? 1 : int'(CLK_HZ / REF_HZ);
	// global region, haddr[11:8] == 0
	localparam logic [3:0] REG_GLOBAL = 4'h0;
	localparam logic [3:0] REG_PORTS = 4'h1;
	localparam logic [7:0] OFS_STAT = 8'h00;
	localparam logic [7:0] OFS_MASK = 8'h04;
	localparam logic [7:0] OFS_LINK = 8'h08;
	localparam logic [7:0] OFS_CB0 = 8'h40;
	// per-port word index, haddr[4:2]; port number in haddr[7:5]
	localparam logic [2:0] PR_CTRL = 3'h0;
	localparam logic [2:0] PR_DATA = 3'h1;
	localparam logic [2:0] PR_COND = 3'h2;
	localparam logic [2:0] PR_TIME = 3'h3;
	localparam logic [2:0] PR_COUNT = 3'h4;
	localparam logic [2:0] PR_TSTAMP = 3'h5;
	localparam logic [2:0] PR_FLAGS = 3'h6;
	// port control fields
	localparam int CT_EN = 0;
	localparam int CT_OUT = 1;
	localparam int CT_OD = 2;
	localparam int CT_CB = 4;
	localparam int CT_COND = 8;
	localparam int CT_TIMED = 10;
	localparam int CT_STB = 11;
	// clock block config fields
	localparam int CB_EXT = 8;
	localparam int DIV_W = 8;
	localparam logic [2:0] CB_RESET_SEL = 3'h0;
	typedef enum logic [1:0] {
		TIO_COND_NONE = 2'b00,
		TIO_COND_EQ = 2'b01,
		TIO_COND_NEQ = 2'b10
	} tio_cond_t;
	typedef struct packed {
		logic en;
		logic dir_out;
		logic od;
		logic [2:0] cb_sel;
		tio_cond_t cond;
		logic timed;
		logic strobe_en;
		logic [31:0] tx_data;
		logic tx_full;
		logic [31:0] shift;
		logic [31:0] rx_data;
		logic rx_valid;
		logic [31:0] cond_val;
		logic [CNT_W-1:0] time_val;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] tstamp;
	} tio_port_t;
	typedef struct packed {
		logic src_ext;
		logic [DIV_W-1:0] div;
		logic [DIV_W-1:0] cnt;
		logic ext_prev;
		logic tick;
	} tio_cb_t;
endpackage : tio_pkg

//--- hw/tio_port_block.sv
// timed i/o ports with clock blocks, pin sharing and an ahb-lite register slave.
// assumes pins and strobes arrive asynchronously; a bus master on hclk.
//
// Functional notes
// - ports of width 1, 4, 8, 16 and 32 bits map onto tile pins
// - all pins of one port share a single direction, in or out
// - ports drive pins high or low, or sample them, optionally on a condition
// - each register access completes with zero wait states
// - open-drain: zero drives low, one leaves the pin undriven; per port
// - data passes through a shift stage and a transfer register
// - each port has a 16-bit counter that can time the transfer
// - counter readable anytime; transfers may wait for a future count
// - counter value saved as timestamp at every transfer
// - pin events go to the tile event outputs and set status bits, which raise irq where unmasked
// - enabling the serial link disables ports on its pins
// - narrower enabled port wins shared pins; unshared wider pins stay usable
// - a port always works at its own declared width
// - six clock blocks; block 0 is the reference clock, others programmable
// - a clock block may be clocked from a 1-bit port pin, optionally divided
// - ports honour an input strobe and generate an output strobe with output data
// - after reset every port uses clock block 0
`timescale 1ns/100ps
module tio_port_block #(
	parameter int LINK_LO = 28
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [tio_pkg::NPIN-1:0] pin_in,
	output logic [tio_pkg::NPIN-1:0] pin_out,
	output logic [tio_pkg::NPIN-1:0] pin_oe,
	input wire logic [tio_pkg::NPORT-1:0] input_strobe,
	output logic [tio_pkg::NPORT-1:0] output_strobe,
	output logic [tio_pkg::NPORT-1:0] port_event,
	output logic irq
);
	typedef struct packed {
		logic ap_valid;
		logic ap_wr;
		logic [11:0] ap_addr;
		logic [31:0] rdata;
		logic ready;
		logic [tio_pkg::NPORT-1:0] stat;
		logic [tio_pkg::NPORT-1:0] mask;
		logic irq;
		logic link_en;
		logic [7:0] ref_cnt;
		logic ref_tick;
		logic [tio_pkg::NPIN-1:0] pin_s1;
		logic [tio_pkg::NPIN-1:0] pin_s2;
		logic [tio_pkg::NPORT-1:0] stb_s1;
		logic [tio_pkg::NPORT-1:0] stb_s2;
		logic [tio_pkg::NPIN-1:0] pin_out;
		logic [tio_pkg::NPIN-1:0] pin_oe;
		logic [tio_pkg::NPORT-1:0] ostb;
		logic [tio_pkg::NPORT-1:0] evt;
		tio_pkg::tio_cb_t [tio_pkg::NCB-1:0] cb;
		tio_pkg::tio_port_t [tio_pkg::NPORT-1:0] port;
	} tio_state_t;

	tio_state_t q;
	tio_state_t d;

	// width mask of a port
	function automatic logic [31:0] wmask(input int w);
		wmask = (w >= 32) ? 32'hFFFFFFFF : ((32'h00000001 << w) - 32'h00000001);
	endfunction : wmask

	// a port whose pins reach into the link's pins is switched off by the link
	function automatic logic port_live(input tio_state_t s, input int p);
		port_live = s.port[p].en &&
			!(s.link_en && (tio_pkg::PORT_BASE[p] + tio_pkg::PORT_W[p] - 1 >= LINK_LO));
	endfunction : port_live

	function automatic logic [31:0] reg_read(input tio_state_t s, input logic [11:0] a);
		logic [2:0] pi;
		logic [31:0] r;
		pi = a[7:5];
		r = 32'h00000000;
		if (a[11:8] == tio_pkg::REG_GLOBAL) begin
			case (a[7:0])
				tio_pkg::OFS_STAT: r[tio_pkg::NPORT-1:0] = s.stat;
				tio_pkg::OFS_MASK: r[tio_pkg::NPORT-1:0] = s.mask;
				tio_pkg::OFS_LINK: r[0] = s.link_en;
				default: begin
					for (int i = 0; i < tio_pkg::NCB; i++) begin
						if (a[7:0] == tio_pkg::OFS_CB0 + 8'(4 * i)) begin
							r[tio_pkg::DIV_W-1:0] = s.cb[i].div;
							r[tio_pkg::CB_EXT] = s.cb[i].src_ext;
						end
					end
				end
			endcase
		end else if (a[11:8] == tio_pkg::REG_PORTS && int'(pi) < tio_pkg::NPORT) begin
			case (a[4:2])
				tio_pkg::PR_CTRL: begin
					r[tio_pkg::CT_EN] = s.port[pi].en;
					r[tio_pkg::CT_OUT] = s.port[pi].dir_out;
					r[tio_pkg::CT_OD] = s.port[pi].od;
					r[tio_pkg::CT_CB +: 3] = s.port[pi].cb_sel;
					r[tio_pkg::CT_COND +: 2] = s.port[pi].cond;
					r[tio_pkg::CT_TIMED] = s.port[pi].timed;
					r[tio_pkg::CT_STB] = s.port[pi].strobe_en;
				end
				tio_pkg::PR_DATA: r = s.port[pi].rx_data;
				tio_pkg::PR_COND: r = s.port[pi].cond_val;
				tio_pkg::PR_TIME: r[15:0] = s.port[pi].time_val;
				tio_pkg::PR_COUNT: r[15:0] = s.port[pi].cnt;
				tio_pkg::PR_TSTAMP: r[15:0] = s.port[pi].tstamp;
				tio_pkg::PR_FLAGS: r[1:0] = {s.port[pi].rx_valid, s.port[pi].tx_full};
				default: r = 32'h00000000;
			endcase
		end
		reg_read = r;
	endfunction : reg_read

	always_comb begin
		logic [2:0] wp;
		logic [31:0] sample;
		logic [31:0] m;
		logic tk;
		logic base;
		logic edge_ext;
		logic time_ok;
		logic cond_ok;
		logic stb_ok;
		logic owned;
		logic bitv;
		wp = q.ap_addr[7:5];
		sample = 32'h00000000;
		m = 32'h00000000;
		tk = 1'b0;
		base = 1'b0;
		edge_ext = 1'b0;
		time_ok = 1'b0;
		cond_ok = 1'b0;
		stb_ok = 1'b0;
		owned = 1'b0;
		bitv = 1'b0;
		d = q;
		d.pin_s1 = pin_in;
		d.pin_s2 = q.pin_s1;
		d.stb_s1 = input_strobe;
		d.stb_s2 = q.stb_s1;
		d.ostb = '0;
		d.evt = '0;
		d.ready = 1'b1;

		// reference tick for clock block 0
		d.ref_tick = (q.ref_cnt == 8'h00);
		d.ref_cnt = (q.ref_cnt == 8'(tio_pkg::REF_DIV - 1)) ? 8'h00 : q.ref_cnt + 8'h01;

		// clock blocks; block 0 is fixed to the reference
		for (int i = 0; i < tio_pkg::NCB; i++) begin
			d.cb[i].ext_prev = q.pin_s2[0];
			edge_ext = q.pin_s2[0] & ~q.cb[i].ext_prev;
			base = (i != 0 && q.cb[i].src_ext) ? edge_ext : q.ref_tick;
			d.cb[i].tick = 1'b0;
			if (base) begin
				if (q.cb[i].cnt >= q.cb[i].div) begin
					d.cb[i].cnt = '0;
					d.cb[i].tick = 1'b1;
				end else begin
					d.cb[i].cnt = q.cb[i].cnt + 8'h01;
				end
			end
		end

		// bus address phase; reads answer in the data phase
		d.ap_valid = hsel & hready & htrans[1];
		d.ap_wr = hwrite;
		d.ap_addr = haddr[11:0];
		if (hsel & hready & htrans[1] & ~hwrite) begin
			d.rdata = reg_read(q, haddr[11:0]);
			if (haddr[11:8] == tio_pkg::REG_PORTS && haddr[4:2] == tio_pkg::PR_DATA &&
				int'(haddr[7:5]) < tio_pkg::NPORT) begin
				d.port[haddr[7:5]].rx_valid = 1'b0;
			end
		end

		// bus data phase writes, except the transmit data register
		if (q.ap_valid & q.ap_wr) begin
			if (q.ap_addr[11:8] == tio_pkg::REG_GLOBAL) begin
				case (q.ap_addr[7:0])
					tio_pkg::OFS_STAT: d.stat = q.stat & ~hwdata[tio_pkg::NPORT-1:0];
					tio_pkg::OFS_MASK: d.mask = hwdata[tio_pkg::NPORT-1:0];
					tio_pkg::OFS_LINK: d.link_en = hwdata[0];
					default: begin
						for (int i = 1; i < tio_pkg::NCB; i++) begin
							if (q.ap_addr[7:0] == tio_pkg::OFS_CB0 + 8'(4 * i)) begin
								d.cb[i].div = hwdata[tio_pkg::DIV_W-1:0];
								d.cb[i].src_ext = hwdata[tio_pkg::CB_EXT];
								d.cb[i].cnt = '0;
							end
						end
					end
				endcase
			end else if (q.ap_addr[11:8] == tio_pkg::REG_PORTS && int'(wp) < tio_pkg::NPORT) begin
				case (q.ap_addr[4:2])
					tio_pkg::PR_CTRL: begin
						d.port[wp].en = hwdata[tio_pkg::CT_EN];
						d.port[wp].dir_out = hwdata[tio_pkg::CT_OUT];
						d.port[wp].od = hwdata[tio_pkg::CT_OD];
						d.port[wp].cb_sel = hwdata[tio_pkg::CT_CB +: 3];
						d.port[wp].cond = tio_pkg::tio_cond_t'(hwdata[tio_pkg::CT_COND +: 2]);
						d.port[wp].timed = hwdata[tio_pkg::CT_TIMED];
						d.port[wp].strobe_en = hwdata[tio_pkg::CT_STB];
					end
					tio_pkg::PR_COND: d.port[wp].cond_val = hwdata;
					tio_pkg::PR_TIME: d.port[wp].time_val = hwdata[15:0];
					default: d.port[wp].cond_val = d.port[wp].cond_val;
				endcase
			end
		end

		// per-port transfer engines
		for (int p = 0; p < tio_pkg::NPORT; p++) begin
			m = wmask(tio_pkg::PORT_W[p]);
			tk = (int'(q.port[p].cb_sel) < tio_pkg::NCB) ? q.cb[q.port[p].cb_sel].tick : 1'b0;
			if (tk) begin
				d.port[p].cnt = q.port[p].cnt + 16'h0001;
			end
			time_ok = !q.port[p].timed || (q.port[p].cnt == q.port[p].time_val);
			sample = (q.pin_s2 >> tio_pkg::PORT_BASE[p]) & m;
			if (q.port[p].dir_out) begin
				if (tk && port_live(q, p) && q.port[p].tx_full && time_ok) begin
					d.port[p].shift = q.port[p].tx_data & m;
					d.port[p].tx_full = 1'b0;
					d.port[p].tstamp = q.port[p].cnt;
					d.ostb[p] = 1'b1;
					d.evt[p] = 1'b1;
					d.stat[p] = 1'b1;
				end
			end else if (tk && port_live(q, p)) begin
				d.port[p].shift = sample;
				case (q.port[p].cond)
					tio_pkg::TIO_COND_EQ: cond_ok = (sample == (q.port[p].cond_val & m));
					tio_pkg::TIO_COND_NEQ: cond_ok = (sample != (q.port[p].cond_val & m));
					default: cond_ok = 1'b1;
				endcase
				stb_ok = !q.port[p].strobe_en || q.stb_s2[p];
				if (time_ok && cond_ok && stb_ok) begin
					d.port[p].rx_data = sample;
					d.port[p].rx_valid = 1'b1;
					d.port[p].tstamp = q.port[p].cnt;
					d.evt[p] = 1'b1;
					d.stat[p] = 1'b1;
				end
			end
		end

		// transmit data write lands after the engines so new data is never dropped
		if (q.ap_valid && q.ap_wr && q.ap_addr[11:8] == tio_pkg::REG_PORTS &&
			q.ap_addr[4:2] == tio_pkg::PR_DATA && int'(wp) < tio_pkg::NPORT) begin
			d.port[wp].tx_data = hwdata & wmask(tio_pkg::PORT_W[wp]);
			d.port[wp].tx_full = 1'b1;
		end

		// pin ownership: lowest index is narrowest, so it wins
		for (int k = 0; k < tio_pkg::NPIN; k++) begin
			owned = 1'b0;
			d.pin_out[k] = 1'b0;
			d.pin_oe[k] = 1'b0;
			for (int p = 0; p < tio_pkg::NPORT; p++) begin
				if (!owned && port_live(q, p) && k >= tio_pkg::PORT_BASE[p] &&
					k < tio_pkg::PORT_BASE[p] + tio_pkg::PORT_W[p]) begin
					owned = 1'b1;
					if (q.port[p].dir_out) begin
						bitv = q.port[p].shift[k - tio_pkg::PORT_BASE[p]];
						d.pin_out[k] = q.port[p].od ? 1'b0 : bitv;
						d.pin_oe[k] = q.port[p].od ? ~bitv : 1'b1;
					end
				end
			end
		end

		d.irq = |(d.stat & q.mask);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
			q.ready <= 1'b1;
			for (int p = 0; p < tio_pkg::NPORT; p++) begin
				q.port[p].cb_sel <= tio_pkg::CB_RESET_SEL;
			end
		end else begin
			q <= d;
		end
	end

	assign hreadyout = q.ready;
	assign hresp = 1'b0;
	assign hrdata = q.rdata;
	assign pin_out = q.pin_out;
	assign pin_oe = q.pin_oe;
	assign output_strobe = q.ostb;
	assign port_event = q.evt;
	assign irq = q.irq;
endmodule : tio_port_block

//--- sim/tb.sv
// self-checking bench for the timed port block over ahb-lite.
// assumes the pin model stands on the pin side; hready is fed from hreadyout.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, pin_in, pin_out, pin_oe, ext_val, ext_en, d5;
	logic [5:0] input_strobe, output_strobe, port_event, ext_stb;
	logic [3:0] d2;
	logic [32:0] rq[$];
	logic [63:0] pq[$];
	string nq[$];
	logic rd_ph = 1'b0;
	logic stb_ph = 1'b0;
	int miscompares = 0;
	int checks = 0;
	int seed = 54;
	tio_port_block #(.LINK_LO(28)) tio_port_block_i (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.input_strobe(input_strobe), .output_strobe(output_strobe),
		.port_event(port_event), .irq(irq));
	tio_pin_model tio_pin_model_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
		.ext_en(ext_en), .ext_stb(ext_stb), .pin_in(pin_in), .input_strobe(input_strobe));
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	task automatic wrap_up();
		if (miscompares == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (hreadyout !== 1'b1) begin
			miscompares++;
			wrap_up();
		end
	endtask : wait_rdy
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e, input string n);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		wait_rdy();
		if (!w) begin
			rq.push_back(e);
			nq.push_back(n);
		end
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		wait_rdy();
	endtask : bus
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 33'h0, "");
	endtask : wr
	function automatic logic [11:0] pa(input int p, input int k);
		return 12'h100 + 12'(p * 32 + k * 4);
	endfunction : pa
	// read data with irq beside it, and pins one cycle after each output strobe
	always @(posedge hclk) begin
		logic [63:0] t;
		string tn;
		if (rd_ph) begin
			t = {31'h0, rq.pop_front()};
			tn = nq.pop_front();
			`CHK(tn, t[32:0], {irq, hrdata})
		end
		if (stb_ph) begin
			t = pq.pop_front();
			`CHK("pins", t, {pin_oe, pin_out})
		end
		rd_ph = hsel && hreadyout && htrans[1] && !hwrite;
		stb_ph = |output_strobe;
	end
	initial begin
		logic [31:0] r;
		logic [15:0] tv;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		ext_val = 32'h0;
		ext_en = 32'h0;
		ext_stb = 6'h0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int p = 0; p < 6; p++) begin
			bus(1'b0, pa(p, 0), 32'h0, 33'h0, "ctrl");
			bus(1'b0, pa(p, 6), 32'h0, 33'h0, "flags");
		end
		wr(12'h0FC, 32'hFFFFFFFF);
		bus(1'b0, 12'h0FC, 32'h0, 33'h0, "unmapped");
		for (int i = 0; i < 6; i++) begin
			r = $random(seed);
			wr(12'h040 + 12'(4 * i), r);
			bus(1'b0, 12'h040 + 12'(4 * i), 0, i == 0 ? 33'h0 : {24'h0, r[8:0]}, "cb");
		end
		d5 = $random(seed);
		d2 = 4'($random(seed));
		wr(pa(5, 0), 32'h3);
		pq.push_back({32'hFFFFFFFF, d5});
		wr(pa(5, 1), d5);
		wr(pa(2, 0), 32'h3);
		pq.push_back({32'hFFFFFFFF, d5[31:4], d2});
		wr(pa(2, 1), {28'h0, d2});
		wr(pa(3, 0), 32'h7);
		pq.push_back({28'hFFFFFF5, 4'hF, d5[31:8], 4'h0, d2});
		wr(pa(3, 1), 32'hA5);
		wr(pa(2, 0), 32'h0);
		wr(pa(3, 0), 32'h0);
		wr(12'h008, 32'h1);
		repeat (3) @(posedge hclk);
		bus(1'b0, 12'h008, 32'h0, 33'h1, "link");
		wr(pa(5, 0), 32'h0);
		wr(12'h008, 32'h0);
		ext_val <= $random(seed);
		ext_en <= 32'hFFFFFFFF;
		wr(12'h000, 32'h3F);
		wr(12'h004, 32'h10);
		wr(pa(4, 0), 32'h1);
		repeat (6) @(posedge hclk);
		bus(1'b0, pa(4, 1), 32'h0, {17'h10000, ext_val[15:0]}, "rx");
		bus(1'b0, pa(4, 6), 32'h0, 33'h100000002, "flags");
		bus(1'b0, 12'h000, 32'h0, 33'h100000010, "stat");
		wr(12'h004, 32'h0);
		bus(1'b0, 12'h000, 32'h0, 33'h10, "masked");
		wr(pa(4, 0), 32'h0);
		wr(12'h000, 32'h10);
		bus(1'b0, 12'h000, 32'h0, 33'h0, "cleared");
		// 1-bit input: equal and not-equal conditions gated by the input strobe
		ext_val <= 32'h00000002;
		wr(pa(1, 2), 32'h1);
		wr(pa(1, 0), 32'h901);
		repeat (4) @(posedge hclk);
		bus(1'b0, pa(1, 6), 32'h0, 33'h0, "no strobe");
		ext_stb <= 6'h02;
		repeat (4) @(posedge hclk);
		bus(1'b0, pa(1, 6), 32'h0, 33'h2, "strobed");
		wr(pa(1, 0), 32'hA01);
		bus(1'b0, pa(1, 1), 32'h0, 33'h1, "rx eq");
		bus(1'b0, pa(1, 6), 32'h0, 33'h0, "neq same");
		ext_val <= 32'h00000000;
		repeat (4) @(posedge hclk);
		bus(1'b0, pa(1, 1), 32'h0, 33'h0, "rx neq");
		bus(1'b0, pa(1, 6), 32'h0, 33'h2, "neq hit");
		wr(pa(1, 0), 32'h0);
		ext_stb <= 6'h00;
		// timed output: the transfer waits for the counter and stamps that count
		tv = 16'($random(seed));
		wr(pa(0, 3), {16'h0, tv});
		wr(pa(0, 0), 32'h403);
		pq.push_back({32'h00000001, 32'h00000001});
		wr(pa(0, 1), 32'h1);
		for (int n = 0; n < 70000 && output_strobe[0] !== 1'b1; n++) begin
			@(posedge hclk);
		end
		if (output_strobe[0] !== 1'b1) begin
			miscompares++;
			wrap_up();
		end
		repeat (3) @(posedge hclk);
		bus(1'b0, pa(0, 5), 32'h0, {17'h0, tv}, "tstamp");
		wr(pa(0, 0), 32'h0);
		repeat (4) @(posedge hclk);
		`CHK("left", 0, rq.size() + pq.size())
		wrap_up();
	end
endmodule : tb

//--- sim/tio_pin_model.sv
// far-side pin model: external hardware with a pull-down on every pin.
// assumes the bench says which pins it drives, their levels and the strobes.
`timescale 1ns/100ps
module tio_pin_model (
	input wire logic [31:0] pin_out,
	input wire logic [31:0] pin_oe,
	input wire logic [31:0] ext_val,
	input wire logic [31:0] ext_en,
	input wire logic [5:0] ext_stb,
	output logic [31:0] pin_in,
	output logic [5:0] input_strobe
);
	// driven pins read back; released and undriven pins sit at the pull-down
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val);
	assign input_strobe = ext_stb;
endmodule : tio_pin_model

//--- sim/tio_port_block_asserts.sv
// checker: bus, event, link and interrupt relations of the timed port block.
// assumes it is bound to tio_port_block and sees only its ports.
`timescale 1ns/100ps
module tio_port_chk #(
	parameter int LINK_LO = 28
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic [31:0] pin_oe,
	input wire logic [5:0] output_strobe,
	input wire logic [5:0] port_event,
	input wire logic irq
);
	logic wr_ap;
	logic rd_ap;
	logic any_wr_q;
	logic lk_ap_q;
	logic link_q;
	assign wr_ap = hsel && hready && htrans[1] && hwrite;
	assign rd_ap = hsel && hready && htrans[1] && !hwrite;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			any_wr_q <= 1'b0;
			lk_ap_q <= 1'b0;
			link_q <= 1'b0;
		end else begin
			any_wr_q <= any_wr_q | wr_ap;
			lk_ap_q <= wr_ap && haddr[11:0] == 12'h008;
			if (lk_ap_q) begin
				link_q <= hwdata[0];
			end
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_ZERO_WAIT: assert property (hreadyout) else $error("wait state");
	AST_OKAY: assert property (!hresp) else $error("error response");
	AST_RD_HOLD: assert property (!$past(rd_ap) |-> $stable(hrdata))
		else $error("read data moved");
	AST_STB_EVT: assert property ((port_event & output_strobe) == output_strobe)
		else $error("strobe without event");
	AST_QUIET: assert property (!any_wr_q |-> pin_oe == 0 && port_event == 0 && !irq)
		else $error("activity before setup");
	AST_LINK_OFF: assert property (link_q && $past(link_q, 2) |-> (pin_oe >> LINK_LO) == 0)
		else $error("link pins driven");
	AST_IRQ_CAUSE: assert property ($rose(irq) |-> port_event != 0 || $past(port_event != 0)
		|| $past(port_event != 0, 2) || $past(wr_ap, 2) || $past(wr_ap, 3))
		else $error("irq without cause");
	AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr_ap, 2) || $past(wr_ap, 3))
		else $error("irq fell without write");
endmodule : tio_port_chk
bind tio_port_block tio_port_chk #(.LINK_LO(LINK_LO)) tio_port_chk_i (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.pin_oe(pin_oe), .output_strobe(output_strobe), .port_event(port_event), .irq(irq));
